//--- rtl/prb_pkg.sv
// Shared types, constants and helpers for the processor bus read link
package prb_pkg;

  // Port width configured per memory sub-region
  typedef enum logic [1:0] {PRB_W32, PRB_W16, PRB_W8} prb_width_t;

  // Origin of a read request from the core
  typedef enum logic [1:0] {PRB_K_IMISS, PRB_K_DMISS, PRB_K_UNCACHED} prb_kind_t;

  // Sub-regions selected by the top address bits
  localparam int unsigned PRB_NREG_DEF     = 4;
  // Beats in a full block read per port width
  localparam logic [4:0]  PRB_BLK_BEATS_32 = 5'h04;
  localparam logic [4:0]  PRB_BLK_BEATS_16 = 5'h08;
  localparam logic [4:0]  PRB_BLK_BEATS_8  = 5'h10;
  // Low address advance per beat
  localparam logic [3:0]  PRB_STEP_32      = 4'h4;
  localparam logic [3:0]  PRB_STEP_16      = 4'h2;
  localparam logic [3:0]  PRB_STEP_8       = 4'h1;
  // Block reads start at the block boundary
  localparam logic [3:0]  PRB_BLOCK_LO     = 4'h0;
  // Recommended acknowledge lead before the last block strobe, in beats
  localparam logic [4:0]  PRB_ACK_LEAD     = 5'h03;
  // Bytes in a full word
  localparam logic [2:0]  PRB_WORD_BYTES   = 3'h4;
  // All byte lane selects inactive (active low)
  localparam logic [3:0]  PRB_BE_OFF       = 4'hf;
  // Reset values of the bus
  localparam logic [31:0] PRB_AD_RST       = 32'h0000_0000;
  localparam logic [3:0]  PRB_LO_RST       = 4'h0;
  localparam logic [4:0]  PRB_BEAT_RST     = 5'h00;

  // Beats of a full block read for a width
  function automatic logic [4:0] prb_blk_beats(input prb_width_t w);
    unique case (w)
      PRB_W32: prb_blk_beats = PRB_BLK_BEATS_32;
      PRB_W16: prb_blk_beats = PRB_BLK_BEATS_16;
      default: prb_blk_beats = PRB_BLK_BEATS_8;
    endcase
  endfunction

endpackage

//--- rtl/prb_if.sv
// Multiplexed address/data read link between the processor end and memory end
`timescale 1ns/1ps
interface prb_if;
  logic        bus_clock_out;
  logic        read_n;
  logic        ale;
  logic        bus_release_n;
  logic        burst_n;
  logic [3:0]  addr_lo;
  logic [31:0] cpu_ad_o;
  logic        cpu_ad_oe;
  logic [31:0] mem_ad_o;
  logic        mem_ad_oe;
  logic        capture_strobe_n;
  logic        ack_n;
  logic [31:0] ad;

  // Resolved shared bus; an undriven bus reads as pulled high
  assign ad = cpu_ad_oe ? cpu_ad_o : (mem_ad_oe ? mem_ad_o : 32'hffff_ffff);

  modport cpu (
    output bus_clock_out, read_n, ale, bus_release_n, burst_n, addr_lo,
    output cpu_ad_o, cpu_ad_oe,
    input  ad, capture_strobe_n, ack_n
  );

  modport mem (
    input  bus_clock_out, read_n, ale, bus_release_n, burst_n, addr_lo, ad,
    output mem_ad_o, mem_ad_oe, capture_strobe_n, ack_n
  );
endinterface

//--- rtl/prb_mem_end.sv
// Memory controller end of the read link: answers reads with data strobes
`timescale 1ns/1ps
module prb_mem_end
  import prb_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // Link
  prb_if.mem               bus,
  // Configuration
  input  wire prb_width_t  port_width_i,
  // Transaction report
  output logic             txn_start_o,
  output logic [31:0]      txn_addr_o,
  output logic [3:0]       txn_be_n_o,
  output logic             txn_burst_o,
  output logic [3:0]       beat_lo_o,
  // Data supply, already placed on the proper lanes
  input  wire logic [31:0] data_i,
  input  wire logic        data_valid_i,
  input  wire logic        data_last_i,
  output logic             data_ready_o
);

  typedef enum logic [1:0] {H_IDLE, H_DATA} prb_mem_state_t;

  prb_mem_state_t state_q;
  logic [4:0]     beat_q;
  logic           rise_en;
  logic           ack_now;
  logic           last_now;
  logic           last_q;
  logic [3:0]     lo_step;

  // Next edge raises the bus clock
  assign rise_en      = ~bus.bus_clock_out;
  // Data only once the processor has released the bus, never past the last datum
  assign data_ready_o = (state_q == H_DATA) && rise_en && !bus.bus_release_n && !bus.read_n
                        && !last_q;

  // Next datum to supply; one step ahead while a strobe is still unsampled
  always_comb begin
    unique case (port_width_i)
      PRB_W32: lo_step = PRB_STEP_32;
      PRB_W16: lo_step = PRB_STEP_16;
      default: lo_step = PRB_STEP_8;
    endcase
    beat_lo_o = bus.capture_strobe_n ? bus.addr_lo : bus.addr_lo + lo_step;
    // Block length from the width, shorter reads from the supply's own mark
    last_now  = txn_burst_o ? (beat_q == 5'(prb_blk_beats(port_width_i) - 5'h01)) : data_last_i;
  end

  // Early acknowledge at the recommended lead of PRB_ACK_LEAD beats before the last block strobe
  always_comb begin
    if (txn_burst_o) begin
      ack_now = (beat_q == 5'(prb_blk_beats(port_width_i) - PRB_ACK_LEAD - 5'h01));
    end else begin
      ack_now = data_last_i;
    end
  end

  // Address capture while the latch enable is high
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_q     <= H_IDLE;
      txn_start_o <= 1'b0;
      txn_addr_o  <= PRB_AD_RST;
      txn_be_n_o  <= PRB_BE_OFF;
      txn_burst_o <= 1'b0;
    end else begin
      txn_start_o <= 1'b0;
      if (state_q == H_IDLE && bus.ale && !bus.read_n) begin
        state_q     <= H_DATA;
        txn_start_o <= 1'b1;
        txn_addr_o  <= {bus.ad[31:4], bus.addr_lo};
        txn_be_n_o  <= bus.ad[3:0];
        txn_burst_o <= !bus.burst_n;
      end else if (state_q == H_DATA && bus.read_n) begin
        state_q <= H_IDLE;
      end
    end
  end

  // Strobe, acknowledge and lane drive, one bus clock per datum
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      bus.mem_ad_o         <= PRB_AD_RST;
      bus.mem_ad_oe        <= 1'b0;
      bus.capture_strobe_n <= 1'b1;
      bus.ack_n            <= 1'b1;
      beat_q               <= PRB_BEAT_RST;
      last_q               <= 1'b0;
    end else if (state_q != H_DATA || bus.read_n) begin
      // Off the bus once the read has ended
      bus.mem_ad_oe        <= 1'b0;
      bus.capture_strobe_n <= 1'b1;
      bus.ack_n            <= 1'b1;
      beat_q               <= PRB_BEAT_RST;
      last_q               <= 1'b0;
    end else if (rise_en) begin
      if (data_ready_o && data_valid_i) begin
        bus.mem_ad_o         <= data_i;
        bus.mem_ad_oe        <= 1'b1;
        bus.capture_strobe_n <= 1'b0;
        bus.ack_n            <= !ack_now;
        beat_q               <= beat_q + 5'h01;
        last_q               <= last_now;
      end else begin
        // Wait state: nothing to sample
        bus.mem_ad_oe        <= 1'b0;
        bus.capture_strobe_n <= 1'b1;
        bus.ack_n            <= 1'b1;
      end
    end
  end

endmodule // prb_mem_end

//--- rtl/prb_cpu_end.sv
// Processor end of the read link: issues single, mini-burst and block reads
//
// Behaviour
// - Bus reads only for uncached or missed references
// - Instruction misses refill blocks; data misses configurable
// - Uncached accesses use single or partial reads
// - Each sub-region has its own port width
// - Transaction forms chosen by port width
// - Read strobe low from start until done
// - Address phase half or one clock
// - Address high bits and byte selects multiplexed
// - Byte selects exact only on 32-bit ports
// - Disabled read mask holds selects inactive
// - Narrow ports use fixed data lanes
// - Latch enable high while address driven
// - Low address counts through the beats
// - Hold address past latch, release at the edge that asserts enable
// - Data enable timing follows hold mode
// - Burst marks only full block reads
// - Capture strobe samples data, last ends read
// - Memory acknowledge must not come too early
// - Recommended acknowledge timing for best speed
// - Without acknowledge, strobe count ends read
// - Any wait states; back-to-back beats allowed
// - Address phase keeps data enable inactive
// - Read starts at rising bus clock edge
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module prb_cpu_end
  import prb_pkg::*;
#(
  parameter int unsigned NREG = PRB_NREG_DEF
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  // Link
  prb_if.cpu               bus,
  // Configuration
  input  wire prb_width_t  region_width_i [NREG],
  input  wire logic        ext_hold_i,
  input  wire logic        big_endian_i,
  input  wire logic        read_mask_en_i,
  input  wire logic        dcache_block_i,
  // Read request from the core
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire logic [31:0] req_addr_i,
  input  wire prb_kind_t   req_kind_i,
  input  wire logic [2:0]  req_bytes_i,
  input  wire logic        cache_hit_i,
  // Read results
  output logic             busy_o,
  output logic             rd_early_o,
  output logic             rd_done_o,
  output logic [127:0]     rd_block_o
);

  localparam int unsigned RB = (NREG > 1) ? $clog2(NREG) : 1;

  typedef enum logic [1:0] {S_IDLE, S_ADDR, S_HOLD, S_DATA} prb_cpu_state_t;

  prb_cpu_state_t state_q;
  logic           bclk_q;
  logic           rise_en;
  logic           accept;
  logic           bus_go;
  logic [RB-1:0]  region;
  prb_width_t     req_w;
  logic           cached;
  logic           blk;
  logic [2:0]     nbytes;
  logic [1:0]     off;
  logic [4:0]     nbeats;
  logic [3:0]     lo_start;
  logic [3:0]     mask;
  logic [3:0]     be_n;
  prb_width_t     width_q;
  logic           ext_q;
  logic           big_q;
  logic [4:0]     left_q;
  logic           acked_q;
  logic           capture;
  logic [31:0]    buf_q [4];

  // Byte lane that carries address offset b for a width
  function automatic logic [1:0] lane_of(input prb_width_t w, input logic big, input logic [1:0] b);
    unique case (w)
      PRB_W32: lane_of = big ? 2'(3 - b) : b;
      PRB_W16: lane_of = big ? 2'(3 - b[0]) : {1'b0, b[0]};
      default: lane_of = big ? 2'h3 : 2'h0;
    endcase
  endfunction

  // Low address advance per beat
  function automatic logic [3:0] step_of(input prb_width_t w);
    unique case (w)
      PRB_W32: step_of = PRB_STEP_32;
      PRB_W16: step_of = PRB_STEP_16;
      default: step_of = PRB_STEP_8;
    endcase
  endfunction

  // Bus clock is the reference divided by two; rising edges land on alternate cycles
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      bclk_q <= 1'b0;
    end else begin
      bclk_q <= ~bclk_q;
    end
  end

  assign bus.bus_clock_out = bclk_q;
  assign rise_en           = ~bclk_q;
  assign busy_o            = (state_q != S_IDLE);

  // Requests only taken where the bus clock rises
  assign req_ready_o = (state_q == S_IDLE) && rise_en;
  assign accept      = req_valid_i && req_ready_o;
  assign cached      = (req_kind_i != PRB_K_UNCACHED);
  assign bus_go      = accept && !(cached && cache_hit_i);
  assign capture     = (state_q == S_DATA) && rise_en && !bus.capture_strobe_n;

  // Decode of the request into a transaction form
  always_comb begin
    region = req_addr_i[31 -: RB];
    req_w  = region_width_i[region];
    blk    = cached && (req_kind_i == PRB_K_IMISS || dcache_block_i);
    // Single-word data miss reads a whole aligned word
    if (cached) begin
      nbytes = PRB_WORD_BYTES;
      off    = 2'h0;
    end else begin
      nbytes = req_bytes_i;
      off    = req_addr_i[1:0];
    end
    if (blk) begin
      nbeats   = prb_blk_beats(req_w);
      lo_start = PRB_BLOCK_LO;
      mask     = 4'hf;
    end else begin
      mask = 4'(((5'h01 << nbytes) - 5'h01) << off);
      unique case (req_w)
        PRB_W32: begin
          nbeats   = 5'h01;
          lo_start = {req_addr_i[3:2], 2'h0};
        end
        PRB_W16: begin
          nbeats   = 5'({1'b0, 2'(3'(off) + nbytes - 3'h1) >> 1} - {2'h0, off[1]} + 3'h1);
          lo_start = {req_addr_i[3:1], 1'b0};
        end
        default: begin
          nbeats   = {2'h0, nbytes};
          lo_start = {req_addr_i[3:2], off};
        end
      endcase
    end
    // Union of bytes used over all beats; exact per beat only on 32-bit ports
    for (int b = 0; b < 4; b++) begin
      be_n[b] = ~(big_endian_i ? mask[3 - b] : mask[b]);
    end
    if (!read_mask_en_i) begin
      be_n = PRB_BE_OFF;
    end
  end

  // Sequencer and link control outputs
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_q           <= S_IDLE;
      bus.read_n        <= 1'b1;
      bus.ale           <= 1'b0;
      bus.bus_release_n <= 1'b1;
      bus.burst_n       <= 1'b1;
      bus.cpu_ad_o      <= PRB_AD_RST;
      bus.cpu_ad_oe     <= 1'b0;
      bus.addr_lo       <= PRB_LO_RST;
      width_q           <= PRB_W32;
      ext_q             <= 1'b0;
      big_q             <= 1'b0;
      left_q            <= PRB_BEAT_RST;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (bus_go) begin
            state_q           <= S_ADDR;
            bus.read_n        <= 1'b0;
            bus.ale           <= 1'b1;
            bus.bus_release_n <= 1'b1;
            bus.burst_n       <= !blk;
            bus.cpu_ad_o      <= {req_addr_i[31:4], be_n};
            bus.cpu_ad_oe     <= 1'b1;
            bus.addr_lo       <= lo_start;
            width_q           <= req_w;
            ext_q             <= ext_hold_i;
            big_q             <= big_endian_i;
            left_q            <= nbeats;
          end
        end
        S_ADDR: begin
          // Latch enable falls after half a clock in both modes
          bus.ale <= 1'b0;
          if (ext_q) begin
            state_q <= S_HOLD;
          end else begin
            state_q           <= S_DATA;
            bus.cpu_ad_oe     <= 1'b0;
            bus.bus_release_n <= 1'b0;
          end
        end
        S_HOLD: begin
          // Extra half clock of address hold, release at the rising edge
          state_q           <= S_DATA;
          bus.cpu_ad_oe     <= 1'b0;
          bus.bus_release_n <= 1'b0;
        end
        S_DATA: begin
          bus.cpu_ad_oe <= 1'b0;
          if (capture) begin
            bus.addr_lo <= bus.addr_lo + step_of(width_q);
            left_q      <= left_q - 5'h01;
            // Last expected strobe ends the read, acknowledge or not
            if (left_q == 5'h01) begin
              state_q           <= S_IDLE;
              bus.read_n        <= 1'b1;
              bus.bus_release_n <= 1'b1;
              bus.burst_n       <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Read buffer: each strobe fills the addressed word's bytes from their lanes
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      for (int w = 0; w < 4; w++) begin
        buf_q[w] <= PRB_AD_RST;
      end
    end else if (capture) begin
      for (int b = 0; b < 4; b++) begin
        if (width_q == PRB_W32 ||
            (width_q == PRB_W16 && b[1] == bus.addr_lo[1]) ||
            (width_q == PRB_W8 && b[1:0] == bus.addr_lo[1:0])) begin
          buf_q[bus.addr_lo[3:2]][8 * lane_of(PRB_W32, big_q, 2'(b)) +: 8] <=
            bus.ad[8 * lane_of(width_q, big_q, 2'(b)) +: 8];
        end
      end
    end
  end

  // Completion and early-use pulses for the core
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      rd_done_o  <= 1'b0;
      rd_early_o <= 1'b0;
      acked_q    <= 1'b0;
    end else begin
      rd_done_o  <= capture && (left_q == 5'h01);
      rd_early_o <= 1'b0;
      if (state_q == S_IDLE) begin
        acked_q <= 1'b0;
      end else if (state_q == S_DATA && rise_en && !bus.ack_n && !acked_q) begin
        // Only the first acknowledge of a read counts
        rd_early_o <= 1'b1;
        acked_q    <= 1'b1;
      end
    end
  end

  // Whole line image, word 0 in the low bits
  generate
    for (genvar g = 0; g < 4; g++) begin : g_line
      assign rd_block_o[32 * g +: 32] = buf_q[g];
    end
  endgenerate

endmodule // prb_cpu_end

//--- verif/prb_properties.sv
// Concurrent checks on the processor bus read link
`timescale 1ns/1ps
module prb_properties (
  // Clock and reset
  input wire logic       ref_clk_i,
  input wire logic       reset_n_i,
  // Link signals
  input wire logic       bus_clock_out,
  input wire logic       read_n,
  input wire logic       ale,
  input wire logic       bus_release_n,
  input wire logic       burst_n,
  input wire logic [3:0] addr_lo,
  input wire logic       cpu_ad_oe,
  input wire logic       mem_ad_oe,
  input wire logic       capture_strobe_n,
  input wire logic       ack_n
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Read start: strobe falls while latch enable is up
  sequence s_start;
    $fell(read_n) ##0 ale;
  endsequence
  // Hand-over half or one bus clock later, depending on hold mode
  sequence s_turn;
    ##[1:2] $fell(bus_release_n);
  endsequence

  property p_start_edge; s_start |-> $rose(bus_clock_out) && cpu_ad_oe; endproperty
  a_start_edge: assert property (p_start_edge) else $error("read start off a bus clock rise");
  property p_ale_drive; ale |-> cpu_ad_oe && !read_n && bus_release_n; endproperty
  a_ale_drive: assert property (p_ale_drive) else $error("latch enable without address drive");
  property p_ale_pulse; $rose(ale) |=> !ale; endproperty
  a_ale_pulse: assert property (p_ale_pulse) else $error("latch enable too long");
  property p_turnaround; s_start |-> s_turn; endproperty
  a_turnaround: assert property (p_turnaround) else $error("bus release late or missing");
  property p_hold_then_off; !bus_release_n |-> !cpu_ad_oe; endproperty
  a_hold_then_off: assert property (p_hold_then_off) else $error("processor drives released bus");
  property p_mem_window; mem_ad_oe |-> !bus_release_n && !read_n; endproperty
  a_mem_window: assert property (p_mem_window) else $error("memory drives outside data phase");
  property p_block_base; s_start ##0 !burst_n |-> addr_lo == 4'h0; endproperty
  a_block_base: assert property (p_block_base) else $error("block read not at block start");
  property p_burst_steady; !read_n && $past(!read_n) |-> $stable(burst_n); endproperty
  a_burst_steady: assert property (p_burst_steady) else $error("burst flag moved mid read");
  property p_end_by_strobe; $rose(read_n) |-> $past(!capture_strobe_n) && bus_release_n; endproperty
  a_end_by_strobe: assert property (p_end_by_strobe) else $error("read ended without a capture");
  property p_strobe_width; $fell(capture_strobe_n) |=> !capture_strobe_n; endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("capture strobe shorter than a bus clock");
  property p_ack_with_strobe; !ack_n |-> !capture_strobe_n; endproperty
  a_ack_with_strobe: assert property (p_ack_with_strobe) else $error("acknowledge without capture");
  property p_strobe_in_data; !capture_strobe_n |-> !read_n && !bus_release_n; endproperty
  a_strobe_in_data: assert property (p_strobe_in_data) else $error("capture outside data phase");
endmodule // prb_properties

//--- verif/prb_tb.sv
// Self-checking bench: processor end and memory end joined over the read link
`timescale 1ns/1ps
module prb_tb;
  import prb_pkg::*;
  // Bench and design signals
  logic         ref_clk_i, reset_n_i, ext_hold_i, big_endian_i, read_mask_en_i, dcache_block_i;
  logic         req_valid_i, req_ready_o, cache_hit_i, busy_o, rd_early_o, rd_done_o;
  logic         txn_start_o, txn_burst_o, data_ready_o;
  logic         data_valid_i = 1'b0, data_last_i = 1'b0;
  logic [2:0]   req_bytes_i;
  logic [3:0]   txn_be_n_o, beat_lo_o;
  logic [4:0]   beats = 5'h00, gap = 5'h00, exp_beats, mem_gap, e;
  logic [31:0]  req_addr_i, txn_addr_o, a, m, data_i = 32'h0000_0000;
  logic [127:0] rd_block_o;
  prb_kind_t    req_kind_i;
  prb_width_t   port_width_i;
  prb_width_t   region_w [4];
  logic [4:0]   blk [3] = '{5'h04, 5'h08, 5'h10};
  logic [4:0]   sw [3] = '{5'h01, 5'h02, 5'h04};
  logic [3:0]   lm [3] = '{4'hc, 4'he, 4'hf};
  int           ur [7] = '{2, 2, 2, 2, 1, 1, 0};
  int           uo [7] = '{0, 1, 1, 0, 1, 2, 3};
  int           un [7] = '{1, 2, 3, 4, 2, 2, 1};
  int           ub [7] = '{1, 2, 3, 4, 2, 1, 1};
  int           err_count = 0, tests_run = 0, starts = 0, earlies = 0, lat;

  prb_if i_prb_if ();
  prb_cpu_end #(.NREG(4)) i_prb_cpu_end (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .bus(i_prb_if.cpu),
    .region_width_i(region_w), .ext_hold_i(ext_hold_i), .big_endian_i(big_endian_i),
    .read_mask_en_i(read_mask_en_i), .dcache_block_i(dcache_block_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_addr_i(req_addr_i), .req_kind_i(req_kind_i), .req_bytes_i(req_bytes_i),
    .cache_hit_i(cache_hit_i), .busy_o(busy_o), .rd_early_o(rd_early_o), .rd_done_o(rd_done_o),
    .rd_block_o(rd_block_o));
  prb_mem_end i_prb_mem_end (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .bus(i_prb_if.mem),
    .port_width_i(port_width_i), .txn_start_o(txn_start_o), .txn_addr_o(txn_addr_o), .txn_be_n_o(txn_be_n_o),
    .txn_burst_o(txn_burst_o), .beat_lo_o(beat_lo_o), .data_i(data_i), .data_valid_i(data_valid_i),
    .data_last_i(data_last_i), .data_ready_o(data_ready_o));
  prb_properties i_prb_properties (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .bus_clock_out(i_prb_if.bus_clock_out), .read_n(i_prb_if.read_n), .ale(i_prb_if.ale),
    .bus_release_n(i_prb_if.bus_release_n), .burst_n(i_prb_if.burst_n), .addr_lo(i_prb_if.addr_lo),
    .cpu_ad_oe(i_prb_if.cpu_ad_oe), .mem_ad_oe(i_prb_if.mem_ad_oe),
    .capture_strobe_n(i_prb_if.capture_strobe_n), .ack_n(i_prb_if.ack_n));

  // Byte held at an address by the modelled memory
  function automatic logic [7:0] bv(input logic [31:0] x);
    return x[7:0] ^ x[31:24];
  endfunction
  // Word as it lands in the read buffer for a byte order
  function automatic logic [31:0] ew(input logic [31:0] x, input logic big);
    logic [31:0] b;
    b = {x[31:2], 2'b00};
    return big ? {bv(b), bv(b + 1), bv(b + 2), bv(b + 3)} : {bv(b + 3), bv(b + 2), bv(b + 1), bv(b)};
  endfunction
  // Memory drives its fixed lanes; idle lanes carry filler to expose lane mix-ups
  function automatic logic [31:0] lanes(input logic [31:0] x, input prb_width_t w, input logic big);
    logic [31:0] h;
    h = {x[31:1], 1'b0};
    case (w)
      PRB_W32: return ew(x, big);
      PRB_W16: return big ? {bv(h), bv(h + 1), 16'ha5a5} : {16'ha5a5, bv(h + 1), bv(h)};
      default: return big ? {bv(x), 24'ha5a5a5} : {24'ha5a5a5, bv(x)};
    endcase
  endfunction
  // Lane mask of the bytes a partial read asks for
  function automatic logic [31:0] msk(input logic [1:0] off, input logic [2:0] nb, input logic big);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
      if (i >= off && i < off + nb) r[(big ? 3 - i : i) * 8 +: 8] = 8'hff;
    return r;
  endfunction

  // Comparison with reporting
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One core request; ready is judged mid-cycle so the accept edge is known
  task automatic rd(input logic [31:0] x, input prb_kind_t k, input logic [2:0] nb, input logic hit,
                    input logic [4:0] eb);
    int s0, e0;
    logic done;
    s0 = starts;
    e0 = earlies;
    @(posedge ref_clk_i);
    port_width_i <= region_w[x[31:30]];
    req_addr_i   <= x;
    req_kind_i   <= k;
    req_bytes_i  <= nb;
    cache_hit_i  <= hit;
    exp_beats    <= eb;
    req_valid_i  <= 1'b1;
    lat = 0;
    @(negedge ref_clk_i);
    while (req_ready_o !== 1'b1 && lat < 100) begin
      @(negedge ref_clk_i);
      lat++;
    end
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
    lat = 1;
    @(negedge ref_clk_i);
    chk("busy once taken", busy_o, !hit);
    while (rd_done_o !== 1'b1 && lat < (hit ? 12 : 400)) begin
      @(negedge ref_clk_i);
      lat++;
    end
    // Pulse counters move at this negedge; read them one later
    done = rd_done_o;
    @(negedge ref_clk_i);
    chk("bus reads started", starts - s0, hit ? 0 : 1);
    chk("read completed", done, !hit);
    chk("early use", earlies - e0, hit ? 0 : 1);
    chk("idle after read", busy_o, 1'b0);
  endtask

  // Memory supply: counts beats, gaps before and between data
  always @(posedge ref_clk_i) begin
    logic t;
    logic [4:0] n;
    t = data_ready_o && data_valid_i;
    n = i_prb_if.ale ? 5'h00 : beats + {4'h0, t};
    beats       <= n;
    data_last_i <= (n == exp_beats - 5'h01);
    data_i      <= lanes({req_addr_i[31:4], beat_lo_o}, port_width_i, big_endian_i);
    if (i_prb_if.ale || t) gap <= mem_gap;
    else if (gap != 5'h00) gap <= gap - 5'h01;
    data_valid_i <= (i_prb_if.ale || t) ? (mem_gap == 5'h00) : (gap <= 5'h01);
  end

  // Pulse counters sampled mid-cycle
  always @(negedge ref_clk_i) begin
    starts  <= starts + int'(txn_start_o === 1'b1);
    earlies <= earlies + int'(rd_early_o === 1'b1);
  end

  // Clock
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // Hang guard, well past the expected run length
  initial begin
    #(50 * 20000);
    err_count++;
    close_out();
  end

  initial begin
    reset_n_i = 1'b0;
    {ext_hold_i, big_endian_i, read_mask_en_i, dcache_block_i, req_valid_i, cache_hit_i} = '0;
    req_addr_i = 32'h0000_0000;
    req_kind_i = PRB_K_IMISS;
    req_bytes_i = 3'h0;
    exp_beats = 5'h01;
    mem_gap = 5'h00;
    port_width_i = PRB_W32;
    region_w = '{PRB_W32, PRB_W16, PRB_W8, PRB_W32};
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    // Block refills on each width, both byte orders, hold modes and beat gaps
    for (int i = 0; i < 6; i++) begin
      big_endian_i <= i[0];
      ext_hold_i   <= i[1];
      mem_gap      <= i[0] ? 5'h03 : 5'h00;
      a = {2'(i / 2), 30'h0123_4568};
      rd(a, PRB_K_IMISS, 3'h0, 1'b0, blk[i / 2]);
      chk("burst flag", txn_burst_o, 1'b1);
      chk("beat count", beats, blk[i / 2]);
      chk("block address", txn_addr_o, {a[31:4], 4'h0});
      chk("block data", rd_block_o, {ew(a | 12, i[0]), ew(a | 8, i[0]), ew((a & ~12) | 4, i[0]),
        ew(a & ~12, i[0])});
    end
    // Data misses: single word unless block refill selected; zero waits
    mem_gap    <= 5'h00;
    ext_hold_i <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      dcache_block_i <= (i == 3);
      a = {2'(i % 3), 30'h0000_0124};
      e = (i == 3) ? 5'h04 : sw[i % 3];
      rd(a, PRB_K_DMISS, 3'h4, 1'b0, e);
      chk("burst flag", txn_burst_o, i == 3);
      chk("beat count", beats, e);
      if (i == 0) chk("zero wait latency", lat, 5);
      if (i < 3) chk("single word", rd_block_o[32 * a[3:2] +: 32], ew(a, big_endian_i));
    end
    // Uncached partial reads: mini-bursts, exact and masked byte selects
    for (int i = 0; i < 7; i++) begin
      read_mask_en_i <= i[0];
      big_endian_i   <= i[1];
      a = {2'(ur[i]), 28'h0123_450, 2'(uo[i])};
      m = msk(a[1:0], 3'(un[i]), i[1]);
      rd(a, PRB_K_UNCACHED, 3'(un[i]), 1'b0, 5'(ub[i]));
      chk("burst flag", txn_burst_o, 1'b0);
      chk("beat count", beats, 5'(ub[i]));
      chk("byte selects", txn_be_n_o, i[0] ? 4'(~{m[24], m[16], m[8], m[0]}) : 4'hf);
      chk("low address", txn_addr_o[3:0] & lm[ur[i]], a[3:0] & lm[ur[i]]);
      chk("partial data", rd_block_o[32 * a[3:2] +: 32] & m, ew(a, i[1]) & m);
    end
    // Cache hit: taken with no bus traffic
    rd(32'h0000_0040, PRB_K_IMISS, 3'h0, 1'b1, 5'h04);
    close_out();
  end
endmodule // prb_tb
